// ### rtl/dcrc_pkg.sv
// package of constants and types for the dual channel rate counter
package dcrc_pkg;
   // register byte offsets
   localparam logic [7:0] DCRC_OFF_CTRL   = 8'h00;
   localparam logic [7:0] DCRC_OFF_CFG_A  = 8'h04;
   localparam logic [7:0] DCRC_OFF_CFG_B  = 8'h08;
   localparam logic [7:0] DCRC_OFF_LIM_A  = 8'h0C;
   localparam logic [7:0] DCRC_OFF_LIM_B  = 8'h10;
   localparam logic [7:0] DCRC_OFF_NORM_A = 8'h14;
   localparam logic [7:0] DCRC_OFF_NORM_B = 8'h18;
   localparam logic [7:0] DCRC_OFF_PRE_A  = 8'h1C;
   localparam logic [7:0] DCRC_OFF_PRE_B  = 8'h20;
   localparam logic [7:0] DCRC_OFF_VAL_A  = 8'h24;
   localparam logic [7:0] DCRC_OFF_VAL_B  = 8'h28;
   localparam logic [7:0] DCRC_OFF_STAT   = 8'h2C;
   localparam logic [7:0] DCRC_OFF_IRQ_ST = 8'h30;
   localparam logic [7:0] DCRC_OFF_IRQ_EN = 8'h34;
   localparam logic [7:0] DCRC_OFF_IRQ_CL = 8'h38;
   localparam logic [7:0] DCRC_OFF_UNIT_A = 8'h40; // three words per channel label
   localparam logic [7:0] DCRC_OFF_UNIT_B = 8'h50;
   localparam int         DCRC_UNIT_CHARS = 10;
   localparam int         DCRC_UNIT_WORDS = 3;

   // ctrl field positions
   localparam int DCRC_CTRL_COUNTER = 0; // 1 = counter mode
   localparam int DCRC_CTRL_DIR_EN  = 1; // direction mode
   localparam int DCRC_CTRL_AVG_EN  = 2;
   localparam int DCRC_CTRL_COMMIT  = 3; // write 1 with a changed setting
   // channel cfg field positions
   localparam int DCRC_CFG_PERIOD   = 0; // input type 1 = period
   localparam int DCRC_CFG_DOWN     = 1; // counter type down
   localparam int DCRC_CFG_LOAD     = 2; // write 1 loads preset

   localparam logic [31:0] DCRC_LIM_RST  = 32'h0BEB_C200; // 1 s window at 200 MHz
   localparam logic [31:0] DCRC_NORM_RST = 32'h0001_0000; // 1.0 in 16.16
   localparam int          DCRC_CLK_MHZ  = 200;
   localparam logic [1:0]  DCRC_RESP_OK  = 2'b00;
   localparam logic [1:0]  DCRC_RESP_ERR = 2'b10;

   // per channel configuration carried as one unit
   typedef struct packed {
      logic        period;
      logic        down;
      logic [31:0] limit;
      logic [31:0] norm;
      logic [31:0] preset;
   } dcrc_chan_cfg_t;

   typedef enum logic [1:0] {
      DCRC_MODE_TACH    = 2'b00,
      DCRC_MODE_PENDING = 2'b01,
      DCRC_MODE_COUNTER = 2'b10
   } dcrc_mode_t;
endpackage : dcrc_pkg

// ### rtl/dcrc_rate_counter.sv
// two channel frequency, period and event counter with axi4-lite registers
//
// Local design decisions: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - ten character unit label per channel readable
// - per channel frequency or period select
// - period mode scales period value, reciprocal of frequency
// - per channel zero speed wait limit
// - low rate flag replaces reading past limit
// - channel b settings independent, same as a
// - direction mode uses channel a only
// - counter mode accumulates per channel totals
// - counter mode scales counts, not rates
// - period only in tach, direction both modes
// - direction signal increments or decrements count
// - mode settings apply after committed change
// - normalization first, then equation stage
// - averaging forced off in counter mode
module dcrc_rate_counter
   import dcrc_pkg::*;
#(
   parameter int CNT_W = 32
) (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic [1:0]  pulse_in,
   input  wire logic        dir_in,
   output logic [1:0]       low_rate,
   output logic             avg_active,
   output logic             irq
);
   // only a 32 bit datapath is built; refuse anything else at elaboration
   if (CNT_W != 32) begin : g_bad_width
      $error("CNT_W must be 32");
   end

   // registers
   logic [31:0]    ctrl_reg;
   dcrc_mode_t     mode_reg;
   logic           dir_act_reg;
   logic [31:0]    cfg_reg   [2];
   logic [31:0]    lim_reg   [2];
   logic [31:0]    norm_reg  [2];
   logic [31:0]    pre_reg   [2];
   logic [31:0]    unit_reg  [2][DCRC_UNIT_WORDS];
   logic [31:0]    val_reg   [2];
   logic [31:0]    cnt_reg   [2];
   logic [31:0]    per_reg   [2];
   logic [31:0]    tmr_reg   [2];
   logic           low_reg   [2];
   logic [1:0]     sync1_reg, sync2_reg, sync3_reg;
   logic           dsync1_reg, dsync2_reg, dsync3_reg;
   logic [1:0]     pin_st_reg;  // accepted pin levels
   logic           dir_st_reg;
   logic [3:0]     ist_reg, ien_reg;
   logic           aw_hold_reg, w_hold_reg;
   logic [7:0]     awaddr_reg;
   logic [31:0]    wdata_reg;
   logic           bvalid_reg, rvalid_reg;
   logic [31:0]    rdata_reg;
   logic [1:0]     rresp_reg, bresp_reg;
   logic           settings_dirty_reg;

   // decode used for reads and writes alike
   function automatic logic known_addr(input logic [7:0] a);
      known_addr = (a <= DCRC_OFF_IRQ_CL) ||
                   (a >= DCRC_OFF_UNIT_A && a < DCRC_OFF_UNIT_A + 8'h0C) ||
                   (a >= DCRC_OFF_UNIT_B && a < DCRC_OFF_UNIT_B + 8'h0C);
   endfunction : known_addr

   // write path: address and data accepted in either order
   wire do_write = aw_hold_reg && w_hold_reg && !bvalid_reg;
   wire do_read  = s_axi_arvalid && !rvalid_reg;
   wire commit_w = do_write && awaddr_reg == DCRC_OFF_CTRL && wdata_reg[DCRC_CTRL_COMMIT];
   assign s_axi_awready = !aw_hold_reg;
   assign s_axi_wready  = !w_hold_reg;
   assign s_axi_arready = !rvalid_reg;
   assign s_axi_bvalid  = bvalid_reg;
   assign s_axi_bresp   = bresp_reg;
   assign s_axi_rvalid  = rvalid_reg;
   assign s_axi_rdata   = rdata_reg;
   assign s_axi_rresp   = rresp_reg;

   // mode actually in force; counter mode disables period
   wire counter_mode = (mode_reg == DCRC_MODE_COUNTER);
   wire dir_mode     = dir_act_reg;
   assign avg_active = ctrl_reg[DCRC_CTRL_AVG_EN] && !counter_mode;
   assign low_rate   = {low_reg[1], low_reg[0]};
   assign irq        = |(ist_reg & ien_reg);

   // three stage synchronisers; a level counts once stages two and three agree
   wire [1:0] rise    = sync2_reg & sync3_reg & ~pin_st_reg;
   wire       dir_now = dir_st_reg;

   // accepted level moves only on agreement, so one late sample cannot make an edge
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sync1_reg  <= 2'h0;
         sync2_reg  <= 2'h0;
         sync3_reg  <= 2'h0;
         pin_st_reg <= 2'h0;
         dsync1_reg <= 1'b0;
         dsync2_reg <= 1'b0;
         dsync3_reg <= 1'b0;
         dir_st_reg <= 1'b0;
      end else begin
         sync1_reg  <= pulse_in;
         sync2_reg  <= sync1_reg;
         sync3_reg  <= sync2_reg;
         pin_st_reg <= (sync2_reg & sync3_reg) | (pin_st_reg & (sync2_reg | sync3_reg));
         dsync1_reg <= dir_in;
         dsync2_reg <= dsync1_reg;
         dsync3_reg <= dsync2_reg;
         dir_st_reg <= (dsync2_reg & dsync3_reg) | (dir_st_reg & (dsync2_reg | dsync3_reg));
      end
   end

   // per channel measurement and counting
   wire  [1:0] ev_low_set, ev_edge;
   for (genvar c = 0; c < 2; c++) begin : g_chan
      wire        chan_on   = (c == 0) || !dir_mode;
      wire        is_period = cfg_reg[c][DCRC_CFG_PERIOD] && !counter_mode;
      wire        edge_c    = rise[c] && chan_on;
      // direction flips the count sense; only the counter mode count uses it
      wire        step_up   = dir_mode ? (cfg_reg[c][DCRC_CFG_DOWN] ^ dir_now)
                                       : !cfg_reg[c][DCRC_CFG_DOWN];
      wire        timeout   = tmr_reg[c] >= lim_reg[c];
      wire [31:0] freq_q    = (per_reg[c] == 32'h0) ? 32'h0
                              : 32'(64'(DCRC_CLK_MHZ) * 64'd1000000 / 64'(per_reg[c]));
      // period is clock count; frequency is its reciprocal
      wire [31:0] raw_q     = counter_mode ? cnt_reg[c]
                              : is_period ? per_reg[c] : freq_q;
      // normalization before any equation stage downstream
      wire [63:0] scaled    = 64'(raw_q) * 64'(norm_reg[c]);
      wire        load_pre  = do_write && awaddr_reg == (c == 0 ? DCRC_OFF_CFG_A : DCRC_OFF_CFG_B)
                              && wdata_reg[DCRC_CFG_LOAD];
      assign ev_edge[c]    = edge_c;
      assign ev_low_set[c] = timeout && !low_reg[c] && !counter_mode;
      // count, timer and flag; a preset load beats an edge in the same cycle
      always_ff @(posedge aclk) begin
         if (!aresetn) begin
            cnt_reg[c] <= 32'h0;
            per_reg[c] <= 32'h0;
            tmr_reg[c] <= 32'h0;
            low_reg[c] <= 1'b0;
            val_reg[c] <= 32'h0;
         end else begin
            if (load_pre) begin
               cnt_reg[c] <= pre_reg[c];
            end else if (edge_c && counter_mode) begin
               cnt_reg[c] <= step_up ? cnt_reg[c] + 32'h1 : cnt_reg[c] - 32'h1;
            end
            if (edge_c) begin
               per_reg[c] <= tmr_reg[c] + 32'h1;
               tmr_reg[c] <= 32'h0;
               low_reg[c] <= 1'b0;
            end else if (!timeout) begin
               tmr_reg[c] <= tmr_reg[c] + 32'h1;
            end else if (!counter_mode) begin
               low_reg[c] <= 1'b1;
            end
            val_reg[c] <= (low_reg[c] && !counter_mode) ? 32'h0 : scaled[47:16];
         end
      end
   end

   // committed mode change; settings take effect only with a real change
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mode_reg           <= DCRC_MODE_TACH;
         dir_act_reg        <= 1'b0;
         settings_dirty_reg <= 1'b0;
      end else begin
         if (do_write && awaddr_reg != DCRC_OFF_CTRL && awaddr_reg <= DCRC_OFF_PRE_B) begin
            settings_dirty_reg <= 1'b1;
         end
         if (commit_w && settings_dirty_reg) begin
            mode_reg           <= ctrl_reg[DCRC_CTRL_COUNTER] ? DCRC_MODE_COUNTER : DCRC_MODE_TACH;
            dir_act_reg        <= ctrl_reg[DCRC_CTRL_DIR_EN];
            settings_dirty_reg <= 1'b0;
         end else if (do_write && awaddr_reg == DCRC_OFF_CTRL &&
                      wdata_reg[DCRC_CTRL_COUNTER] != counter_mode) begin
            mode_reg <= DCRC_MODE_PENDING == mode_reg ? mode_reg : mode_reg;
         end
      end
   end

   // axi write side and configuration storage
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_hold_reg <= 1'b0;
         w_hold_reg  <= 1'b0;
         awaddr_reg  <= 8'h00;
         wdata_reg   <= 32'h0;
         bvalid_reg  <= 1'b0;
         bresp_reg   <= DCRC_RESP_OK;
         ctrl_reg    <= 32'h0;
         ien_reg     <= 4'h0;
         ist_reg     <= 4'h0;
         for (int c = 0; c < 2; c++) begin
            cfg_reg[c]  <= 32'h0;
            lim_reg[c]  <= DCRC_LIM_RST;
            norm_reg[c] <= DCRC_NORM_RST;
            pre_reg[c]  <= 32'h0;
            for (int w = 0; w < DCRC_UNIT_WORDS; w++) unit_reg[c][w] <= 32'h0;
         end
      end else begin
         if (s_axi_awvalid && !aw_hold_reg) begin
            aw_hold_reg <= 1'b1;
            awaddr_reg  <= {s_axi_awaddr[7:2], 2'b00};
         end
         if (s_axi_wvalid && !w_hold_reg) begin
            w_hold_reg <= 1'b1;
            wdata_reg  <= s_axi_wdata;
         end
         if (s_axi_bvalid && s_axi_bready) bvalid_reg <= 1'b0;
         if (do_write) begin
            aw_hold_reg <= 1'b0;
            w_hold_reg  <= 1'b0;
            bvalid_reg  <= 1'b1;
            bresp_reg   <= known_addr(awaddr_reg) ? DCRC_RESP_OK : DCRC_RESP_ERR;
            case (awaddr_reg)
               DCRC_OFF_CTRL:   ctrl_reg    <= {28'h0, 1'b0, wdata_reg[2:0]};
               DCRC_OFF_CFG_A:  cfg_reg[0]  <= {30'h0, wdata_reg[1:0]};
               DCRC_OFF_CFG_B:  cfg_reg[1]  <= {30'h0, wdata_reg[1:0]};
               DCRC_OFF_LIM_A:  lim_reg[0]  <= wdata_reg;
               DCRC_OFF_LIM_B:  lim_reg[1]  <= wdata_reg;
               DCRC_OFF_NORM_A: norm_reg[0] <= wdata_reg;
               DCRC_OFF_NORM_B: norm_reg[1] <= wdata_reg;
               DCRC_OFF_PRE_A:  pre_reg[0]  <= wdata_reg;
               DCRC_OFF_PRE_B:  pre_reg[1]  <= wdata_reg;
               DCRC_OFF_IRQ_EN: ien_reg     <= wdata_reg[3:0];
               default: begin
                  for (int c = 0; c < 2; c++)
                     for (int w = 0; w < DCRC_UNIT_WORDS; w++)
                        if (awaddr_reg == (c == 0 ? DCRC_OFF_UNIT_A : DCRC_OFF_UNIT_B) + 8'(4 * w))
                           unit_reg[c][w] <= (w == 2) ? {16'h0, wdata_reg[15:0]} : wdata_reg;
               end
            endcase
         end
         // sticky events: set wins over a clear in the same cycle
         ist_reg <= (ist_reg & ~((do_write && awaddr_reg == DCRC_OFF_IRQ_CL) ? wdata_reg[3:0] : 4'h0))
                    | {ev_edge, ev_low_set};
      end
   end

   // combinational read mux on the raw read address
   logic [31:0] rd_mux;
   always_comb begin
      rd_mux = 32'h0;
      case ({s_axi_araddr[7:2], 2'b00})
         DCRC_OFF_CTRL:   rd_mux = {28'h0, dir_act_reg, ctrl_reg[2:0]};
         DCRC_OFF_CFG_A:  rd_mux = cfg_reg[0];
         DCRC_OFF_CFG_B:  rd_mux = cfg_reg[1];
         DCRC_OFF_LIM_A:  rd_mux = lim_reg[0];
         DCRC_OFF_LIM_B:  rd_mux = lim_reg[1];
         DCRC_OFF_NORM_A: rd_mux = norm_reg[0];
         DCRC_OFF_NORM_B: rd_mux = norm_reg[1];
         DCRC_OFF_PRE_A:  rd_mux = pre_reg[0];
         DCRC_OFF_PRE_B:  rd_mux = pre_reg[1];
         DCRC_OFF_VAL_A:  rd_mux = val_reg[0];
         DCRC_OFF_VAL_B:  rd_mux = dir_mode ? 32'h0 : val_reg[1];
         DCRC_OFF_STAT:   rd_mux = {26'h0, avg_active, mode_reg, counter_mode, low_reg[1], low_reg[0]};
         DCRC_OFF_IRQ_ST: rd_mux = {28'h0, ist_reg};
         DCRC_OFF_IRQ_EN: rd_mux = {28'h0, ien_reg};
         DCRC_OFF_UNIT_A:         rd_mux = unit_reg[0][0];
         DCRC_OFF_UNIT_A + 8'h04: rd_mux = unit_reg[0][1];
         DCRC_OFF_UNIT_A + 8'h08: rd_mux = unit_reg[0][2];
         DCRC_OFF_UNIT_B:         rd_mux = unit_reg[1][0];
         DCRC_OFF_UNIT_B + 8'h04: rd_mux = unit_reg[1][1];
         DCRC_OFF_UNIT_B + 8'h08: rd_mux = unit_reg[1][2];
         default:                 rd_mux = 32'h0;
      endcase
   end

   // read answer one cycle after the address is taken, held until rready
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_reg <= 1'b0;
         rdata_reg  <= 32'h0;
         rresp_reg  <= DCRC_RESP_OK;
      end else if (do_read) begin
         rvalid_reg <= 1'b1;
         rdata_reg  <= rd_mux;
         rresp_reg  <= known_addr({s_axi_araddr[7:2], 2'b00}) ? DCRC_RESP_OK : DCRC_RESP_ERR;
      end else if (s_axi_rready) begin
         rvalid_reg <= 1'b0;
      end
   end
endmodule : dcrc_rate_counter
`default_nettype wire

// ### testbench/dcrc_rate_counter_sva.sv
// assertions on the bus handshakes and status outputs of the rate counter
`timescale 1ns/1ps
`default_nettype none
module dcrc_rate_counter_sva
   import dcrc_pkg::*;
(
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic [7:0]  s_axi_araddr,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic        avg_active,
   input wire logic        irq
);
   logic st_rd; // read under way targets status
   // remember where the pending read points; only looked at while rvalid
   always_ff @(posedge aclk) begin
      if (s_axi_arvalid && s_axi_arready) begin
         st_rd <= (s_axi_araddr == DCRC_OFF_STAT);
      end
   end
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   sequence both_s; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready; endsequence
   sequence st_s; s_axi_rvalid && st_rd; endsequence
   rst_idle_a: assert property ($rose(aresetn) |-> !irq && !s_axi_bvalid && !s_axi_rvalid && s_axi_arready)
      else $error("outputs busy after reset");
   ar_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read data late");
   ar_refuse_a: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read address taken while data pending");
   r_once_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
      else $error("read data repeated");
   b_once_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("write response repeated");
   b_follow_a: assert property (both_s |-> ##[1:2] s_axi_bvalid)
      else $error("write response late");
   stat_avg_a: assert property (st_s |-> s_axi_rdata[5] == avg_active)
      else $error("status average bit differs from output");
   ctr_avg_a: assert property (st_s ##0 s_axi_rdata[2] |-> !avg_active)
      else $error("averaging active in counter mode");
endmodule : dcrc_rate_counter_sva
bind dcrc_rate_counter dcrc_rate_counter_sva chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
   .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
   .s_axi_rvalid, .s_axi_rready, .avg_active, .irq);
`default_nettype wire

// ### testbench/dcrc_sensor_model.sv
// speed sensor model driving pulse trains on both channels
`timescale 1ns/1ps
`default_nettype none
module dcrc_sensor_model (
   input wire logic   clk,
   output logic [1:0] pulse
);
   initial pulse = 2'b00;
   // whole periods only; the line rests low between bursts like a stopped wheel
   task automatic burst(input int ch, input int n, input int per);
      for (int i = 0; i < n; i++) begin
         @(posedge clk) pulse[ch] <= 1'b1;
         repeat (per / 2) @(posedge clk);
         pulse[ch] <= 1'b0;
         repeat (per - per / 2 - 1) @(posedge clk);
      end
   endtask : burst
endmodule : dcrc_sensor_model
`default_nettype wire

// ### testbench/test_dual_channel_rate_counter.sv
// self-checking bench of the dual channel rate counter
`timescale 1ns/1ps
`default_nettype none
module test_dual_channel_rate_counter
   import dcrc_pkg::*;
;
   logic        aclk, aresetn, dir_in, irq, avg_active, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
   logic        s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [7:0]  s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, d;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp, pulse_in, low_rate, rr;
   logic [15:0] seed;
   logic [31:0] lab [$];
   int          err_count, compares, q [2], nrm [2];
   dcrc_rate_counter dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pulse_in,
      .dir_in, .low_rate, .avg_active, .irq);
   dcrc_sensor_model sens (.clk(aclk), .pulse(pulse_in));
   // 200 MHz
   always #2.5 aclk = ~aclk;
   // model: measured quantity times 16.16 scale
   function automatic logic [31:0] val(input int c);
      return 32'((longint'(q[c]) * nrm[c]) >>> 16);
   endfunction : val
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction : lfsr
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         err_count++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   // ready and answers are taken at the rising edge, before that edge's own updates land
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      logic ta, tw;
      ta = 1'b0;
      tw = 1'b0;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
      while (!ta || !tw) begin
         @(posedge aclk);
         if (!ta && s_axi_awready) begin
            ta = 1'b1;
            s_axi_awvalid <= 1'b0;
         end
         if (!tw && s_axi_wready) begin
            tw = 1'b1;
            s_axi_wvalid <= 1'b0;
         end
      end
      do @(posedge aclk); while (!s_axi_bvalid);
      rr = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a);
      @(posedge aclk);
      s_axi_araddr <= a;
      {s_axi_arvalid, s_axi_rready} <= 2'b11;
      do @(posedge aclk); while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      do @(posedge aclk); while (!s_axi_rvalid);
      d = s_axi_rdata;
      rr = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask : rd
   task automatic rchk(input logic [7:0] a, input logic [31:0] e, input string nm);
      rd(a);
      chk(nm, d, e);
   endtask : rchk
   task automatic report_and_stop();
      $display("compares %0d err_count %0d", compares, err_count);
      if (err_count == 0 && compares > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : report_and_stop
   // whole run is a few hundred cycles
   initial begin
      repeat (20000) @(posedge aclk);
      err_count++;
      report_and_stop();
   end
   // reset, defaults, labels, rates, interrupt, counter and direction modes
   initial begin
      {aclk, aresetn, dir_in, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, err_count, compares} = '0;
      s_axi_wstrb = 4'hF; // full words only
      seed = 16'h79BE;
      nrm = '{DCRC_NORM_RST, DCRC_NORM_RST};
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      rchk(DCRC_OFF_LIM_A, DCRC_LIM_RST, "lim_a");
      rchk(DCRC_OFF_NORM_B, DCRC_NORM_RST, "norm_b");
      rchk(8'hFC, 32'h0, "bad_rdata");
      chk("bad_rresp", 32'(rr), 32'(DCRC_RESP_ERR));
      wr(8'hFC, 32'h1);
      chk("bad_bresp", 32'(rr), 32'(DCRC_RESP_ERR));
      // labels, the last word holding two characters
      for (int i = 0; i < 6; i++) begin
         seed = lfsr(seed);
         lab.push_back({seed, lfsr(seed)});
         wr(DCRC_OFF_UNIT_A + 8'(i / 3 * 16 + i % 3 * 4), lab[i]);
      end
      foreach (lab[i]) begin
         rchk(DCRC_OFF_UNIT_A + 8'(i / 3 * 16 + i % 3 * 4), i % 3 == 2 ? lab[i] & 32'hFFFF : lab[i], "unit");
      end
      // zero speed on A, interrupt masked, enabled and cleared
      wr(DCRC_OFF_LIM_A, 32'd40);
      repeat (60) @(posedge aclk);
      chk("low", 32'(low_rate), 32'h1);
      rchk(DCRC_OFF_VAL_A, 32'h0, "val_low");
      rchk(DCRC_OFF_IRQ_ST, 32'h1, "irq_st");
      chk("irq_off", 32'(irq), 32'h0);
      wr(DCRC_OFF_IRQ_EN, 32'h1);
      chk("irq_on", 32'(irq), 32'h1);
      sens.burst(0, 6, 10);
      chk("low_gone", 32'(low_rate), 32'h0);
      q[0] = DCRC_CLK_MHZ * 1000000 / 10;
      rchk(DCRC_OFF_VAL_A, val(0), "freq_a");
      wr(DCRC_OFF_IRQ_CL, 32'hF);
      chk("irq_clr", 32'(irq), 32'h0);
      // period on A with doubled scale, frequency on B
      wr(DCRC_OFF_CFG_A, 32'h1);
      wr(DCRC_OFF_NORM_A, 32'h0002_0000);
      nrm[0] = 32'h0002_0000;
      sens.burst(0, 4, 12);
      q[0] = 12;
      rchk(DCRC_OFF_VAL_A, val(0), "period_a");
      sens.burst(1, 4, 8);
      q[1] = DCRC_CLK_MHZ * 1000000 / 8;
      rchk(DCRC_OFF_VAL_B, val(1), "freq_b");
      // counter mode waits for a committed settings change
      wr(DCRC_OFF_CTRL, 32'h5);
      chk("avg_tach", 32'(avg_active), 32'h1);
      rd(DCRC_OFF_STAT);
      chk("not_yet", 32'(d[2]), 32'h0);
      wr(DCRC_OFF_PRE_A, 32'd5);
      wr(DCRC_OFF_CTRL, 32'hD);
      rd(DCRC_OFF_STAT);
      chk("counter", 32'(d[2]), 32'h1);
      chk("avg_ctr", 32'(avg_active), 32'h0);
      q = '{5, 0};
      for (int c = 0; c < 2; c++) begin
         wr(DCRC_OFF_CFG_A + 8'(4 * c), 32'h4);
         sens.burst(c, 3 + c, 6);
         q[c] += 3 + c;
         rchk(DCRC_OFF_VAL_A + 8'(4 * c), val(c), "count");
      end
      // direction mode: A only, down while the direction bit is low
      wr(DCRC_OFF_CFG_B, 32'h0);
      wr(DCRC_OFF_CTRL, 32'h3); // mode and direction requested before the commit
      wr(DCRC_OFF_CTRL, 32'hB);
      rd(DCRC_OFF_CTRL);
      chk("dir_on", 32'(d[3]), 32'h1);
      wr(DCRC_OFF_CFG_A, 32'h4);
      q[0] = 5;
      for (int k = 0; k < 2; k++) begin
         dir_in <= 1'(k);
         sens.burst(0, 2 + k, 6);
         q[0] += k ? 3 : -2;
         rchk(DCRC_OFF_VAL_A, val(0), "dir_count");
      end
      rchk(DCRC_OFF_VAL_B, 32'h0, "b_idle");
      report_and_stop();
   end
endmodule : test_dual_channel_rate_counter
`default_nettype wire
